/* hdl/dcs_input_port.sv */
`timescale 1ns/10ps
// Function
// - Dual-port mode: first port is I sample, captured on configured edge.
// - Single-port mode: first port carries I and Q, steered by select line.
// - Single-port: select low at capture edge stores word as Q.
// - Single-port: select high at capture edge stores word as I.
// - Dual-port: select pin is Q sample MSB, not a selector.
// - Alt clock pin is Q bit 14 dual-port, alternate clock single-port.
// - Dual-port: second port low bits plus two shared pins form Q.
// - Sample word clock pin is input or driven output, as configured.
// - Words read as two's complement or offset binary per format setting.
module dcs_input_port
  import dcs_pkg::*;
(
  input  wire logic               i_mclk,                     // core clock, 20 MHz
  input  wire logic               i_rst_n,                    // synchronous reset, active low
  input  wire logic               i_ce,                       // clock enable, freezes state
  input  wire logic               i_link_clk,                 // sample word clock, pin level
  input  wire logic               i_cfg_single_port,          // 1: single-port mode
  input  wire logic               i_cfg_fall_edge,            // 1: capture on falling edge
  input  wire logic               i_cfg_clk_out,              // 1: device drives word clock
  input  wire logic               i_cfg_alt_clk,              // 1: alt pin carries the clock
  input  wire logic               i_cfg_offset_bin,           // 1: offset binary input
  input  wire logic [WORD_W-1:0]  i_first_port,               // first input port
  input  wire logic               i_select_or_q_top_bit,      // select line or Q MSB
  input  wire logic               i_alt_clock_or_q_bit_fourteen, // alt pin, input side
  input  wire logic [B_LOW_W-1:0] i_second_port_low_bits,     // Q bits 13..0
  input  wire logic               i_sample_word_clock,        // word clock pin, input side
  output logic                    o_sample_word_clock,        // word clock pin, output side
  output logic                    o_sample_word_clock_oe_n,   // low while driving
  output logic                    o_alt_clock_or_q_bit_fourteen, // alt pin, output side
  output logic                    o_alt_clock_or_q_bit_fourteen_oe_n, // low while driving
  output logic [WORD_W-1:0]       o_i_sample,                 // I sample, two's complement
  output logic                    o_i_valid,                  // I sample strobe
  output logic [WORD_W-1:0]       o_q_sample,                 // Q sample, two's complement
  output logic                    o_q_valid,                  // Q sample strobe
  output logic                    o_single_port,              // mode in effect
  output logic                    o_link_busy                 // stays low; cleared in the same cycle a request would set it
);
  dcs_xfer_if x ();

  // Core-domain configuration
  logic             single_q, single_d;
  logic             fall_q, fall_d;
  logic             clkout_q, clkout_d;
  logic             altclk_q, altclk_d;
  logic             offbin_q, offbin_d;
  logic             ce_q;

  // Word clock divider and pin drive
  logic [DIV_W-1:0] div_q, div_d;
  logic             dclk_q, dclk_d;
  logic             dclk_oe_n_q, dclk_oe_n_d;
  logic             alt_q, alt_d;
  logic             alt_oe_n_q, alt_oe_n_d;

  // Receive side of the link handshake
  logic             req_s1_q, req_s2_q;
  logic             req_s1_d, req_s2_d;
  logic             ack_q, ack_d;
  logic [WORD_W-1:0] i_smp_q, i_smp_d, q_smp_q, q_smp_d;
  logic             i_vld_q, i_vld_d, q_vld_q, q_vld_d;
  logic             busy_q, busy_d;
  logic             new_w;
  logic [WORD_W-1:0] fmt_flip_w;

  // Link-domain synchronisers
  logic             l_rst_s1_q, l_rst_s2_q;
  logic             l_ce_s1_q, l_ce_s2_q;
  logic             l_single_s1_q, l_single_s2_q;
  logic             l_fall_s1_q, l_fall_s2_q;
  logic             l_ack_s1_q, l_ack_s2_q;

  always_comb begin
    single_d = single_q;
    fall_d   = fall_q;
    clkout_d = clkout_q;
    altclk_d = altclk_q;
    offbin_d = offbin_q;
    if (i_ce) begin
      single_d = i_cfg_single_port;
      fall_d   = i_cfg_fall_edge;
      clkout_d = i_cfg_clk_out;
      altclk_d = i_cfg_alt_clk;
      offbin_d = i_cfg_offset_bin;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      single_q <= CFG_SINGLE_RST;
      fall_q   <= CFG_FALL_RST;
      clkout_q <= CFG_CLKOUT_RST;
      altclk_q <= CFG_ALTCLK_RST;
      offbin_q <= CFG_OFFBIN_RST;
      ce_q     <= 1'b0;
    end else begin
      single_q <= single_d;
      fall_q   <= fall_d;
      clkout_q <= clkout_d;
      altclk_q <= altclk_d;
      offbin_q <= offbin_d;
      ce_q     <= i_ce;
    end
  end

  // Divider runs only when the device owns the clock
  always_comb begin
    div_d       = div_q;
    dclk_d      = dclk_q;
    dclk_oe_n_d = dclk_oe_n_q;
    alt_d       = alt_q;
    alt_oe_n_d  = alt_oe_n_q;
    if (i_ce) begin
      dclk_oe_n_d = ~clkout_q;
      if (!clkout_q) begin
        div_d  = '0;
        dclk_d = 1'b0;
      end else if (div_q == DIV_W'(DCLK_HALF_CYC - 1)) begin
        div_d  = '0;
        dclk_d = ~dclk_q;
      end else begin
        div_d = div_q + DIV_W'(1);
      end
      alt_oe_n_d = ~(single_q && altclk_q && clkout_q);
      alt_d      = single_q && altclk_q && clkout_q && dclk_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_q       <= '0;
      dclk_q      <= 1'b0;
      dclk_oe_n_q <= 1'b1;
      alt_q       <= 1'b0;
      alt_oe_n_q  <= 1'b1;
    end else begin
      div_q       <= div_d;
      dclk_q      <= dclk_d;
      dclk_oe_n_q <= dclk_oe_n_d;
      alt_q       <= alt_d;
      alt_oe_n_q  <= alt_oe_n_d;
    end
  end

  // Request toggle crosses in on two flops
  // Not gated by enable: a frozen core must still see the latest level
  always_comb begin
    req_s1_d = x.req;
    req_s2_d = req_s1_q;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_s1_d;
      req_s2_q <= req_s2_d;
    end
  end

  assign new_w = (req_s2_q != ack_q) && i_ce;

  // Offset binary becomes two's complement by MSB flip
  assign fmt_flip_w = offbin_q ? {1'b1, {(WORD_W-1){1'b0}}} : '0;

  always_comb begin
    ack_d   = ack_q;
    i_smp_d = i_smp_q;
    q_smp_d = q_smp_q;
    i_vld_d = 1'b0;
    q_vld_d = 1'b0;
    busy_d  = busy_q;
    if (i_ce) begin
      busy_d = req_s2_q != ack_q;
    end else begin
      i_vld_d = i_vld_q;
      q_vld_d = q_vld_q;
    end
    // Words are stable on the link side until ack returns
    if (new_w) begin
      ack_d   = req_s2_q;
      busy_d  = 1'b0;
      if (x.i_vld) begin
        i_smp_d = x.i_word ^ fmt_flip_w;
        i_vld_d = 1'b1;
      end
      if (x.q_vld) begin
        q_smp_d = x.q_word ^ fmt_flip_w;
        q_vld_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ack_q   <= 1'b0;
      i_smp_q <= '0;
      q_smp_q <= '0;
      i_vld_q <= 1'b0;
      q_vld_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      ack_q   <= ack_d;
      i_smp_q <= i_smp_d;
      q_smp_q <= q_smp_d;
      i_vld_q <= i_vld_d;
      q_vld_q <= q_vld_d;
      busy_q  <= busy_d;
    end
  end

  // Link-domain reset; release lags by two link edges
  // Link clock must run during reset or the capture side stays stale
  always_ff @(posedge i_link_clk) begin
    l_rst_s1_q    <= i_rst_n;
    l_rst_s2_q    <= l_rst_s1_q;
  end

  // Link-domain copies of core levels
  // Config levels are quasi-static, so a plain two-flop pass is enough
  always_ff @(posedge i_link_clk) begin
    l_ce_s1_q     <= ce_q;
    l_ce_s2_q     <= l_ce_s1_q;
    l_single_s1_q <= single_q;
    l_single_s2_q <= l_single_s1_q;
    l_fall_s1_q   <= fall_q;
    l_fall_s2_q   <= l_fall_s1_q;
  end

  // Ack toggle back to the link side closes the handshake
  always_ff @(posedge i_link_clk) begin
    l_ack_s1_q    <= ack_q;
    l_ack_s2_q    <= l_ack_s1_q;
  end

  assign x.rst_n_s  = l_rst_s2_q;
  assign x.ce_s     = l_ce_s2_q;
  assign x.single_s = l_single_s2_q;
  assign x.fall_s   = l_fall_s2_q;
  assign x.ack_s    = l_ack_s2_q;

  // Pin loopback feeds i_link_clk; the alt pin is data only in dual-port mode
  dcs_link_capture u_cap (
    .i_link_clk   (i_link_clk),
    .i_first_port (i_first_port),
    .i_sel_top    (i_select_or_q_top_bit),
    .i_q_bit14    (i_alt_clock_or_q_bit_fourteen),
    .i_b_low      (i_second_port_low_bits),
    .x            (x.link)
  );

  assign o_sample_word_clock                = dclk_q;
  assign o_sample_word_clock_oe_n           = dclk_oe_n_q;
  assign o_alt_clock_or_q_bit_fourteen      = alt_q;
  assign o_alt_clock_or_q_bit_fourteen_oe_n = alt_oe_n_q;
  assign o_i_sample                         = i_smp_q;
  assign o_i_valid                          = i_vld_q;
  assign o_q_sample                         = q_smp_q;
  assign o_q_valid                          = q_vld_q;
  assign o_single_port                      = single_q;
  // All outputs come straight from registers
  assign o_link_busy                        = busy_q;
endmodule // dcs_input_port

/* common/dcs_pkg.sv */
package dcs_pkg;
  // Sample word geometry
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned B_LOW_W     = 14;
  localparam int unsigned Q_BIT14_POS = 14;
  localparam int unsigned Q_MSB_POS   = 15;

  // Timing of the driven sample word clock
  localparam int unsigned MCLK_PERIOD_NS = 50;
  localparam int unsigned DCLK_HALF_NS   = 100;
  localparam int unsigned DCLK_HALF_CYC_RAW =
    (DCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned DCLK_HALF_CYC =
    (DCLK_HALF_CYC_RAW < 1) ? 1 : DCLK_HALF_CYC_RAW;
  localparam int unsigned DIV_W = 4;

  // Configuration reset values
  localparam logic CFG_SINGLE_RST = 1'b0;
  localparam logic CFG_FALL_RST   = 1'b0;
  localparam logic CFG_CLKOUT_RST = 1'b0;
  localparam logic CFG_ALTCLK_RST = 1'b0;
  localparam logic CFG_OFFBIN_RST = 1'b0;

  // Link handshake states
  typedef enum logic [0:0] {
    DCS_IDLE,
    DCS_WAIT_ACK
  } dcs_hs_state_t;
endpackage : dcs_pkg

/* common/dcs_xfer_if.sv */
`timescale 1ns/10ps
interface dcs_xfer_if;
  import dcs_pkg::*;
  // Levels from the core domain, resynchronised at the link
  logic              rst_n_s;
  logic              ce_s;
  logic              single_s;
  logic              fall_s;
  // Words from the link domain, stable while req differs from ack
  logic [WORD_W-1:0] i_word;
  logic [WORD_W-1:0] q_word;
  logic              i_vld;
  logic              q_vld;
  logic              req;
  logic              ack_s;

  modport link (input rst_n_s, ce_s, single_s, fall_s, ack_s,
                output i_word, q_word, i_vld, q_vld, req);
  modport core (output rst_n_s, ce_s, single_s, fall_s, ack_s,
                input i_word, q_word, i_vld, q_vld, req);
endinterface : dcs_xfer_if

/* hdl/dcs_link_capture.sv */
`timescale 1ns/10ps
module dcs_link_capture
  import dcs_pkg::*;
(
  input  wire logic               i_link_clk,   // sample word clock as seen at the pin
  input  wire logic [WORD_W-1:0]  i_first_port, // first input port
  input  wire logic               i_sel_top,    // select_or_q_top_bit
  input  wire logic               i_q_bit14,    // alt_clock_or_q_bit_fourteen, input side
  input  wire logic [B_LOW_W-1:0] i_b_low,      // second_port_low_bits
  dcs_xfer_if.link                x             // toward the core domain
);
  logic [WORD_W-1:0]  pos_a_q, neg_a_q;
  logic               pos_sel_q, neg_sel_q;
  logic               pos_b14_q, neg_b14_q;
  logic [B_LOW_W-1:0] pos_bl_q, neg_bl_q;
  logic [WORD_W-1:0]  a_w, qd_w;
  logic               sel_w;
  logic [WORD_W-1:0]  pi_q, pi_d, pq_q, pq_d, ti_q, ti_d, tq_q, tq_d;
  logic               piv_q, piv_d, pqv_q, pqv_d, tiv_q, tiv_d, tqv_q, tqv_d;
  logic               req_q, req_d;
  dcs_hs_state_t      st_q, st_d;

  // Both edges always sampled; edge choice is a data mux, not a clock mux
  always_ff @(posedge i_link_clk) begin
    pos_a_q   <= i_first_port;
    pos_sel_q <= i_sel_top;
    pos_b14_q <= i_q_bit14;
    pos_bl_q  <= i_b_low;
  end

  always_ff @(negedge i_link_clk) begin
    neg_a_q   <= i_first_port;
    neg_sel_q <= i_sel_top;
    neg_b14_q <= i_q_bit14;
    neg_bl_q  <= i_b_low;
  end

  always_comb begin
    a_w   = x.fall_s ? neg_a_q : pos_a_q;
    sel_w = x.fall_s ? neg_sel_q : pos_sel_q;
    qd_w  = x.fall_s ? {neg_sel_q, neg_b14_q, neg_bl_q} : {pos_sel_q, pos_b14_q, pos_bl_q};
    pi_d  = pi_q;
    piv_d = piv_q;
    pq_d  = pq_q;
    pqv_d = pqv_q;
    if (x.ce_s) begin
      if (!x.single_s) begin
        pi_d  = a_w;
        piv_d = 1'b1;
        pq_d  = qd_w;
        pqv_d = 1'b1;
      end else if (sel_w) begin
        pi_d  = a_w;
        piv_d = 1'b1;
      end else begin
        pq_d  = a_w;
        pqv_d = 1'b1;
      end
    end
    ti_d  = ti_q;
    tq_d  = tq_q;
    tiv_d = tiv_q;
    tqv_d = tqv_q;
    req_d = req_q;
    st_d  = st_q;
    case (st_q)
      DCS_IDLE: begin
        if (x.ce_s && (piv_q || pqv_q)) begin
          ti_d  = pi_q;
          tq_d  = pq_q;
          tiv_d = piv_q;
          tqv_d = pqv_q;
          // A word landing this cycle stays pending for the next transfer
          piv_d = x.single_s ? (sel_w && x.ce_s) : x.ce_s;
          pqv_d = x.single_s ? (!sel_w && x.ce_s) : x.ce_s;
          req_d = ~req_q;
          st_d  = DCS_WAIT_ACK;
        end
      end
      DCS_WAIT_ACK: begin
        if (x.ack_s == req_q) begin
          st_d = DCS_IDLE;
        end
      end
      default: st_d = DCS_IDLE;
    endcase
  end

  always_ff @(posedge i_link_clk) begin
    if (!x.rst_n_s) begin
      pi_q  <= '0;
      pq_q  <= '0;
      ti_q  <= '0;
      tq_q  <= '0;
      piv_q <= 1'b0;
      pqv_q <= 1'b0;
      tiv_q <= 1'b0;
      tqv_q <= 1'b0;
      req_q <= 1'b0;
      st_q  <= DCS_IDLE;
    end else begin
      pi_q  <= pi_d;
      pq_q  <= pq_d;
      ti_q  <= ti_d;
      tq_q  <= tq_d;
      piv_q <= piv_d;
      pqv_q <= pqv_d;
      tiv_q <= tiv_d;
      tqv_q <= tqv_d;
      req_q <= req_d;
      st_q  <= st_d;
    end
  end

  assign x.i_word = ti_q;
  assign x.q_word = tq_q;
  assign x.i_vld  = tiv_q;
  assign x.q_vld  = tqv_q;
  assign x.req    = req_q;
endmodule // dcs_link_capture

/* testbench/dcs_src_model.sv */
`timescale 1ns/10ps
module dcs_src_model
  import dcs_pkg::*;
(
  input  wire logic               i_link_clk,   // word clock wire
  input  wire logic               i_fall,       // capture on falling edge
  input  wire logic               i_single,     // single-port mode
  input  wire logic               i_sel,        // channel to send
  input  wire logic [WORD_W-1:0]  i_word_a,     // first port word
  input  wire logic [WORD_W-1:0]  i_word_b,     // Q word, dual mode
  output logic      [WORD_W-1:0]  o_first_port, // first port pins
  output logic                    o_sel_top,    // select or Q MSB
  output logic                    o_alt,        // alt pin
  output logic      [B_LOW_W-1:0] o_b_low       // second port low bits
);
  initial begin
    {o_first_port, o_sel_top, o_alt, o_b_low} = '0;
  end
  // Launch opposite the capture edge, so setup and hold are met
  always @(i_link_clk) begin
    if (i_link_clk == i_fall) begin
      o_first_port <= i_word_a;
      o_sel_top    <= i_single ? i_sel : i_word_b[Q_MSB_POS];
      o_alt        <= i_single ? 1'b0 : i_word_b[Q_BIT14_POS];
      o_b_low      <= i_single ? '0 : i_word_b[B_LOW_W-1:0];
    end
  end
endmodule // dcs_src_model

/* testbench/dcs_input_port_checker.sv */
`timescale 1ns/10ps
module dcs_input_port_checker
  import dcs_pkg::*;
(
  input wire logic              i_mclk,                 // core clock
  input wire logic              i_rst_n,                // reset
  input wire logic              i_ce,                   // enable
  input wire logic              i_cfg_single_port,      // mode
  input wire logic              i_cfg_clk_out,          // clock out
  input wire logic              i_cfg_alt_clk,          // alt clock
  input wire logic              o_sample_word_clock,    // clock out
  input wire logic              o_sample_word_clock_oe_n, // enable
  input wire logic              o_alt_clock_or_q_bit_fourteen_oe_n, // enable
  input wire logic [WORD_W-1:0] o_i_sample,             // I word
  input wire logic              o_i_valid,              // I strobe
  input wire logic              o_q_valid,              // Q strobe
  input wire logic              o_single_port           // mode
);
  default clocking cb @(posedge i_mclk); endclocking
  logic       alt_want;
  logic       sp_q;
  logic [3:0] age_q;
  logic [3:0] age_d;
  assign alt_want = i_cfg_single_port & i_cfg_alt_clk & i_cfg_clk_out;
  // Words in flight may still carry the old mode
  always_comb begin
    age_d = (o_single_port != sp_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
  end
  always_ff @(posedge i_mclk) begin
    sp_q  <= o_single_port;
    age_q <= i_rst_n ? age_d : 4'h0;
  end
  sequence s_on;
    i_rst_n && i_ce && i_cfg_clk_out;
  endsequence
  sequence s_run;
    i_rst_n && i_ce;
  endsequence
  AST_RST_QUIET: assert property (!i_rst_n |=> o_sample_word_clock_oe_n && !o_i_valid
    && !o_q_valid && o_i_sample == '0) else $error("outputs active in reset");
  AST_OE_ON: assert property (disable iff (!i_rst_n) s_on ##1 i_rst_n ##1 i_rst_n
    |-> !o_sample_word_clock_oe_n) else $error("word clock not driven");
  AST_CLK_IDLE: assert property (disable iff (!i_rst_n) s_run ##0 !i_cfg_clk_out
    ##1 i_rst_n ##1 i_rst_n |-> o_sample_word_clock_oe_n && !o_sample_word_clock)
    else $error("word clock driven while input");
  AST_CLK_HI: assert property (disable iff (!i_rst_n) $rose(o_sample_word_clock) ##0 s_on
    ##1 s_on |-> o_sample_word_clock ##1 !o_sample_word_clock) else $error("high phase wrong");
  AST_CLK_LO: assert property (disable iff (!i_rst_n) $fell(o_sample_word_clock) ##0 s_on
    ##1 s_on |-> !o_sample_word_clock ##1 o_sample_word_clock) else $error("low phase wrong");
  AST_MODE: assert property (disable iff (!i_rst_n) s_run ##1 i_rst_n
    |-> o_single_port == $past(i_cfg_single_port)) else $error("mode not applied");
  AST_ALT_OE: assert property (disable iff (!i_rst_n) s_run ##1 i_rst_n ##1 i_rst_n
    |-> o_alt_clock_or_q_bit_fourteen_oe_n == !$past(alt_want, 2)) else $error("alt pin enable");
  AST_I_PULSE: assert property (disable iff (!i_rst_n) i_ce && o_i_valid
    |=> !o_i_valid) else $error("I strobe too long");
  AST_Q_PULSE: assert property (disable iff (!i_rst_n) i_ce && o_q_valid
    |=> !o_q_valid) else $error("Q strobe too long");
  AST_DUAL_PAIR: assert property (disable iff (!i_rst_n) !o_single_port && age_q == 4'hf
    |-> o_i_valid == o_q_valid) else $error("dual words not paired");
endmodule // dcs_input_port_checker

bind dcs_input_port dcs_input_port_checker u_dcs_input_port_checker (.i_mclk, .i_rst_n,
  .i_ce, .i_cfg_single_port, .i_cfg_clk_out, .i_cfg_alt_clk, .o_sample_word_clock,
  .o_sample_word_clock_oe_n, .o_alt_clock_or_q_bit_fourteen_oe_n, .o_i_sample, .o_i_valid,
  .o_q_valid, .o_single_port);

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import dcs_pkg::*;
  logic               mclk, lclk, rst_n, ce, c_sp, c_fe, c_co, c_ac, c_ob, sel;
  logic               st, alt_m, swc, swc_oe_n, alt_o, alt_oe_n, ivld, qvld, sp;
  logic               link_w, alt_w, busy;
  logic [WORD_W-1:0]  wa, wb, fp, isamp, qsamp;
  logic [B_LOW_W-1:0] bl;
  logic [15:0]        qtab [3] = '{16'h8a5c, 16'h4c33, 16'hf0f0};
  int                 err_total, n_checks, vi, n;

  // Pins resolved from who drives them
  assign link_w = swc_oe_n ? lclk : swc;
  assign alt_w  = alt_oe_n ? alt_m : alt_o;

  dcs_input_port u_dcs_input_port (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce),
    .i_link_clk(link_w), .i_cfg_single_port(c_sp), .i_cfg_fall_edge(c_fe),
    .i_cfg_clk_out(c_co), .i_cfg_alt_clk(c_ac), .i_cfg_offset_bin(c_ob),
    .i_first_port(fp), .i_select_or_q_top_bit(st), .i_alt_clock_or_q_bit_fourteen(alt_w),
    .i_second_port_low_bits(bl), .i_sample_word_clock(link_w),
    .o_sample_word_clock(swc), .o_sample_word_clock_oe_n(swc_oe_n),
    .o_alt_clock_or_q_bit_fourteen(alt_o), .o_alt_clock_or_q_bit_fourteen_oe_n(alt_oe_n),
    .o_i_sample(isamp), .o_i_valid(ivld), .o_q_sample(qsamp), .o_q_valid(qvld),
    .o_single_port(sp), .o_link_busy(busy));
  dcs_src_model u_dcs_src_model (.i_link_clk(link_w), .i_fall(c_fe), .i_single(c_sp),
    .i_sel(sel), .i_word_a(wa), .i_word_b(wb), .o_first_port(fp), .o_sel_top(st),
    .o_alt(alt_m), .o_b_low(bl));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Link clock unrelated in phase to the core clock
  initial begin
    lclk = 1'b0;
    #1.7;
    forever #3 lclk = ~lclk;
  end
  // Counted mid-cycle, away from the edge that launches the strobe
  always @(negedge mclk) if (ivld === 1'b1) vi++;

  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #5;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Words are decimated, so hold each long enough to land
  task automatic send(input logic [15:0] a, input logic [15:0] b, input logic s);
    wa = a;
    wb = b;
    sel = s;
    step(30);
  endtask
  task automatic count_rises(output int r);
    logic p;
    p = swc;
    r = 0;
    repeat (40) begin
      step(1);
      if (swc === 1'b1 && p === 1'b0) r++;
      p = swc;
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Tests take about 16 us; allow over twelve times that
  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  initial begin
    {rst_n, c_sp, c_fe, c_co, c_ac, c_ob, sel} = '0;
    ce = 1'b1;
    wa = '0;
    wb = '0;
    {err_total, n_checks, vi} = '0;
    step(2);
    chk({swc_oe_n, alt_oe_n, ivld, qvld, sp, swc, busy}, 7'h60);
    chk(isamp, 16'h0000);
    rst_n = 1'b1;
    step(10);
    foreach (qtab[k]) begin
      n = vi;
      send(16'h8123 ^ qtab[k], qtab[k], 1'b0);
      chk(isamp, 16'h8123 ^ qtab[k]);
      chk(qsamp[Q_MSB_POS], qtab[k][Q_MSB_POS]);
      chk(qsamp[Q_BIT14_POS], qtab[k][Q_BIT14_POS]);
      chk(qsamp[B_LOW_W-1:0], qtab[k][B_LOW_W-1:0]);
      chk(vi > n, 1'b1);
    end
    c_fe = 1'b1;
    send(16'h5a5a, 16'h3c3c, 1'b0);
    chk({isamp, qsamp}, 32'h5a5a3c3c);
    c_ob = 1'b1;
    send(16'h0012, 16'hff00, 1'b0);
    chk({isamp, qsamp}, 32'h80127f00);
    c_ob = 1'b0;
    c_fe = 1'b0;
    send(16'h0012, 16'hff00, 1'b0);
    chk({isamp, qsamp}, 32'h0012ff00);
    $display("Test dual finished");
    c_sp = 1'b1;
    send(16'h1234, 16'h0000, 1'b1);
    chk(isamp, 16'h1234);
    chk(sp, 1'b1);
    send(16'habcd, 16'h0000, 1'b0);
    chk({isamp, qsamp}, 32'h1234abcd);
    $display("Test single finished");
    c_co = 1'b1;
    c_ac = 1'b1;
    step(2);
    chk({swc_oe_n, alt_oe_n}, 2'b00);
    count_rises(n);
    chk(n, 10);
    chk(alt_o, swc);
    send(16'h0f0f, 16'h0000, 1'b1);
    chk(isamp, 16'h0f0f);
    c_co = 1'b0;
    c_ac = 1'b0;
    step(2);
    chk({swc_oe_n, alt_oe_n, swc}, 3'b110);
    $display("Test clock finished");
    finish_test();
  end
endmodule // testbench
